// ===== core/pcr_pkg.sv
// Purpose: Shared constants and types for the pushed compare and repeat unit.
// Assumes: 32-bit data words, AXI4-Lite register access.
// Notes: Control/status layout keeps the mode field at [3:2] and counter at [23:12].
package pcr_pkg;
   localparam logic [31:0] PCR_CTRL_OFS = 32'h0000_0000;
   localparam logic [31:0] PCR_WDATA_OFS = 32'h0000_0004;
   localparam logic [31:0] PCR_RDATA_OFS = 32'h0000_0008;
   localparam logic [31:0] PCR_CLEAR_OFS = 32'h0000_000C;
   localparam int PCR_MODE_LO = 2;
   localparam int PCR_MODE_HI = 3;
   localparam int PCR_MASK_LO = 8;
   localparam int PCR_MASK_HI = 11;
   localparam int PCR_CNT_LO = 12;
   localparam int PCR_CNT_HI = 23;
   localparam int PCR_FAULT_BIT = 5;
   localparam int PCR_CMP_BIT = 4;
   localparam int PCR_BUSY_BIT = 0;
   localparam int PCR_WR_BIT = 1;
   localparam int PCR_CNT_W = 12;
   localparam logic [3:0] PCR_MASK_RST = 4'hF;
   localparam logic [1:0] PCR_RESP_OKAY = 2'h0;
   localparam logic [1:0] PCR_RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      PCR_MODE_NORMAL = 2'b00,
      PCR_MODE_COMPARE = 2'b01,
      PCR_MODE_VERIFY = 2'b10,
      PCR_MODE_RSVD = 2'b11
   } pcr_mode_t;
   typedef struct packed {
      logic write;
      logic [31:0] data;
   } pcr_req_t;
   typedef struct packed {
      logic fault;
      logic [31:0] data;
   } pcr_rsp_t;
endpackage

// ===== core/pcr_lane_cmp.sv
// Purpose: Masked byte lane comparison of read data against held data.
// Assumes: Four byte lanes.
// Notes: A lane whose mask bit is zero counts as matching.
`timescale 1ns/10ps
module pcr_lane_cmp
   import pcr_pkg::*;
(
   // Operands
   input wire logic [31:0] held_data,
   input wire logic [31:0] read_data,
   input wire logic [3:0] byte_lane_mask,
   // Result
   output logic all_match
);
   logic [3:0] lane_ok;
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_lane
         assign lane_ok[i] = !byte_lane_mask[i] ||
            (held_data[8*i +: 8] == read_data[8*i +: 8]); // RQ6 RQ17
      end
   endgenerate
   assign all_match = &lane_ok;
endmodule

// ===== core/pcr_axil_slave.sv
// Purpose: AXI4-Lite slave exposing four word registers.
// Assumes: One write and one read outstanding at most.
// Notes: Write takes address and data in either order; answers one cycle later.
`timescale 1ns/10ps
module pcr_axil_slave
   import pcr_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Write channels
   input wire logic [31:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   // Read channels
   input wire logic [31:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // Register side
   output logic wr_stb,
   output logic [1:0] wr_idx,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   output logic [1:0] rd_idx,
   input wire logic [31:0] rd_word
);
   logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
   logic [31:0] awaddr_reg, awaddr_next, wdata_reg, wdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic aw_ok, ar_ok;

   assign s_awready = !aw_have_reg && !bvalid_reg;
   assign s_wready = !w_have_reg && !bvalid_reg;
   assign s_arready = !rvalid_reg;
   assign aw_ok = (awaddr_reg[31:4] == 28'h0000000) && (awaddr_reg[1:0] == 2'h0);
   assign ar_ok = (s_araddr[31:4] == 28'h0000000) && (s_araddr[1:0] == 2'h0);
   assign wr_stb = aw_have_reg && w_have_reg && !bvalid_reg && aw_ok;
   assign wr_idx = awaddr_reg[3:2];
   assign wr_data = wdata_reg;
   assign wr_strb = wstrb_reg;
   assign rd_idx = s_araddr[3:2];

   always_comb begin
      aw_have_next = aw_have_reg;
      w_have_next = w_have_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      if (s_awvalid && s_awready) begin
         aw_have_next = 1'b1;
         awaddr_next = s_awaddr;
      end
      if (s_wvalid && s_wready) begin
         w_have_next = 1'b1;
         wdata_next = s_wdata;
         wstrb_next = s_wstrb;
      end
      if (aw_have_reg && w_have_reg && !bvalid_reg) begin
         aw_have_next = 1'b0;
         w_have_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = aw_ok ? PCR_RESP_OKAY : PCR_RESP_SLVERR;
      end
      if (bvalid_reg && s_bready) begin
         bvalid_next = 1'b0;
      end
   end

   always_comb begin
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (s_arvalid && s_arready) begin
         rvalid_next = 1'b1;
         rdata_next = ar_ok ? rd_word : 32'h0000_0000;
         rresp_next = ar_ok ? PCR_RESP_OKAY : PCR_RESP_SLVERR;
      end else if (rvalid_reg && s_rready) begin
         rvalid_next = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         awaddr_reg <= 32'h0000_0000;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= PCR_RESP_OKAY;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= PCR_RESP_OKAY;
      end else begin
         aw_have_reg <= aw_have_next;
         w_have_reg <= w_have_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   assign s_bvalid = bvalid_reg;
   assign s_bresp = bresp_reg;
   assign s_rvalid = rvalid_reg;
   assign s_rdata = rdata_reg;
   assign s_rresp = rresp_reg;
endmodule

// ===== core/pcr_unit.sv
// Purpose: Pushed compare/verify and transaction repeat control for a debug port.
// Assumes: Access port answers each request with one response, data and fault.
// Notes: A request starts by a write to the data word register while idle; control
//        sets its kind, mode, mask and repeat count beforehand.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
// Function
// [RQ1] Pushed mode: hold write data, issue read
// [RQ2] Compare mode: match sets compare flag
// [RQ3] Verify mode: mismatch sets compare flag
// [RQ4] Compare flag set cancels pending repeats
// [RQ5] Mode field at control bits 3:2
// [RQ6] Byte lane mask limits the comparison
// [RQ7] Debugger avoids reads in pushed mode
// [RQ8] Repeat counter replays one request
// [RQ9] Twelve-bit counter, N gives N+1 transactions
// [RQ10] Counter stays zero, never reloads
// [RQ11] Nonzero counter decrements after success, repeats
// [RQ12] No repeat on zero, fault or compare
// [RQ13] Stopped counter keeps last successful value
// [RQ14] Repeated writes reuse the first data
// [RQ15] Sticky flags hold until explicitly cleared
// [RQ16] Fault set discards further port transactions
// [RQ17] Masked-off lanes count as matching
// [RQ18] Compare result settles before repeat decision
module pcr_unit
   import pcr_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // AXI4-Lite write
   input wire logic [31:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   // AXI4-Lite read
   input wire logic [31:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // Access port request
   output pcr_req_t ap_req,
   output logic ap_req_valid,
   input wire logic ap_req_ready,
   // Access port response
   input wire pcr_rsp_t ap_rsp,
   input wire logic ap_rsp_valid
);
   typedef enum logic [1:0] {
      PCR_IDLE = 2'b00,
      PCR_ISSUE = 2'b01,
      PCR_WAIT = 2'b10
   } pcr_state_t;

   pcr_state_t state_reg, state_next;
   logic [1:0] mode_reg, mode_next;
   logic [3:0] mask_reg, mask_next;
   logic [PCR_CNT_W-1:0] cnt_reg, cnt_next;
   logic cmp_reg, cmp_next, fault_reg, fault_next;
   logic wr_kind_reg, wr_kind_next;
   logic [31:0] held_reg, held_next, rdata_reg, rdata_next;
   logic req_wr_reg, req_wr_next;
   logic wr_stb;
   logic [1:0] wr_idx, rd_idx;
   logic [31:0] wr_data, rd_word, ctrl_word;
   logic [3:0] wr_strb;
   logic all_match, pushed, cmp_hit, start, ok_done;

   pcr_axil_slave u_bus (
      .core_clk(core_clk),
      .rst(rst),
      .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid),
      .s_awready(s_awready),
      .s_wdata(s_wdata),
      .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid),
      .s_wready(s_wready),
      .s_bresp(s_bresp),
      .s_bvalid(s_bvalid),
      .s_bready(s_bready),
      .s_araddr(s_araddr),
      .s_arvalid(s_arvalid),
      .s_arready(s_arready),
      .s_rdata(s_rdata),
      .s_rresp(s_rresp),
      .s_rvalid(s_rvalid),
      .s_rready(s_rready),
      .wr_stb(wr_stb),
      .wr_idx(wr_idx),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .rd_idx(rd_idx),
      .rd_word(rd_word)
   );

   pcr_lane_cmp u_cmp (
      .held_data(held_reg),
      .read_data(ap_rsp.data),
      .byte_lane_mask(mask_reg),
      .all_match(all_match)
   );

   assign pushed = (mode_reg == PCR_MODE_COMPARE) || (mode_reg == PCR_MODE_VERIFY);
   // Only written requests are compared; reads in pushed mode are left undefined
   assign cmp_hit = pushed && req_wr_reg && // RQ7
      (((mode_reg == PCR_MODE_COMPARE) && all_match) || // RQ2
       ((mode_reg == PCR_MODE_VERIFY) && !all_match)); // RQ3
   assign ok_done = (state_reg == PCR_WAIT) && ap_rsp_valid && !ap_rsp.fault;

   always_comb begin
      ctrl_word = 32'h0000_0000;
      ctrl_word[PCR_BUSY_BIT] = (state_reg != PCR_IDLE);
      ctrl_word[PCR_WR_BIT] = wr_kind_reg;
      ctrl_word[PCR_MODE_HI:PCR_MODE_LO] = mode_reg;
      ctrl_word[PCR_CMP_BIT] = cmp_reg;
      ctrl_word[PCR_FAULT_BIT] = fault_reg;
      ctrl_word[PCR_MASK_HI:PCR_MASK_LO] = mask_reg;
      ctrl_word[PCR_CNT_HI:PCR_CNT_LO] = cnt_reg; // RQ13
   end

   always_comb begin
      unique case (rd_idx)
         PCR_CTRL_OFS[3:2]: rd_word = ctrl_word;
         PCR_WDATA_OFS[3:2]: rd_word = held_reg;
         PCR_RDATA_OFS[3:2]: rd_word = rdata_reg;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // A write to the data word while idle launches a request unless a fault is sticky
   assign start = wr_stb && (wr_idx == PCR_WDATA_OFS[3:2]) && (state_reg == PCR_IDLE) &&
      !fault_reg; // RQ16

   always_comb begin
      state_next = state_reg;
      mode_next = mode_reg;
      mask_next = mask_reg;
      cnt_next = cnt_reg;
      cmp_next = cmp_reg;
      fault_next = fault_reg;
      wr_kind_next = wr_kind_reg;
      held_next = held_reg;
      rdata_next = rdata_reg;
      req_wr_next = req_wr_reg;
      if (wr_stb && (wr_idx == PCR_CTRL_OFS[3:2]) && (state_reg == PCR_IDLE)) begin
         if (wr_strb[0]) begin
            mode_next = wr_data[PCR_MODE_HI:PCR_MODE_LO]; // RQ5
            wr_kind_next = wr_data[PCR_WR_BIT];
         end
         if (wr_strb[1]) begin
            mask_next = wr_data[PCR_MASK_HI:PCR_MASK_LO];
         end
         if (wr_strb[2] && wr_strb[1]) begin
            cnt_next = wr_data[PCR_CNT_HI:PCR_CNT_LO]; // RQ9
         end
      end
      if (wr_stb && (wr_idx == PCR_CLEAR_OFS[3:2])) begin
         if (wr_data[PCR_CMP_BIT]) begin
            cmp_next = 1'b0;
         end
         if (wr_data[PCR_FAULT_BIT]) begin
            fault_next = 1'b0;
         end
      end
      unique case (state_reg)
         PCR_IDLE: begin
            if (start) begin
               held_next = wr_data; // RQ1 RQ14
               req_wr_next = wr_kind_reg;
               state_next = PCR_ISSUE;
            end
         end
         PCR_ISSUE: begin
            if (ap_req_valid && ap_req_ready) begin
               state_next = PCR_WAIT;
            end
         end
         PCR_WAIT: begin
            if (ap_rsp_valid) begin
               rdata_next = ap_rsp.data;
               if (ap_rsp.fault) begin
                  fault_next = 1'b1; // RQ15
                  state_next = PCR_IDLE;
               end else if (cmp_hit) begin
                  cmp_next = 1'b1; // RQ4 RQ18
                  state_next = PCR_IDLE;
               end else if ((cnt_reg != '0) && !cmp_reg && !fault_reg) begin // RQ12
                  cnt_next = cnt_reg - 1'b1; // RQ8 RQ11
                  state_next = PCR_ISSUE;
               end else begin
                  state_next = PCR_IDLE; // RQ10
               end
            end
         end
         default: state_next = PCR_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_reg <= PCR_IDLE;
         mode_reg <= PCR_MODE_NORMAL;
         mask_reg <= PCR_MASK_RST;
         cnt_reg <= '0;
         cmp_reg <= 1'b0;
         fault_reg <= 1'b0;
         wr_kind_reg <= 1'b0;
         held_reg <= 32'h0000_0000;
         rdata_reg <= 32'h0000_0000;
         req_wr_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         mode_reg <= mode_next;
         mask_reg <= mask_next;
         cnt_reg <= cnt_next;
         cmp_reg <= cmp_next;
         fault_reg <= fault_next;
         wr_kind_reg <= wr_kind_next;
         held_reg <= held_next;
         rdata_reg <= rdata_next;
         req_wr_reg <= req_wr_next;
      end
   end

   assign ap_req_valid = (state_reg == PCR_ISSUE);
   always_comb begin
      ap_req.data = held_reg; // RQ14
      ap_req.write = req_wr_reg && !pushed; // RQ1
   end

   a_push_read: assert property (@(posedge core_clk) disable iff (rst) // RQ1
      ap_req_valid && pushed |-> !ap_req.write)
      else $error("pushed request issued as a write");
   a_cmp_set: assert property (@(posedge core_clk) disable iff (rst) // RQ2
      ok_done && req_wr_reg && (mode_reg == PCR_MODE_COMPARE) && all_match |=> cmp_reg)
      else $error("compare flag not set on hit");
   a_verify_set: assert property (@(posedge core_clk) disable iff (rst) // RQ3
      ok_done && req_wr_reg && (mode_reg == PCR_MODE_VERIFY) && !all_match |=> cmp_reg)
      else $error("verify mismatch did not set flag");
   a_cancel_rep: assert property (@(posedge core_clk) disable iff (rst) // RQ4
      ok_done ##1 $rose(cmp_reg) |-> (state_reg == PCR_IDLE) && $stable(cnt_reg))
      else $error("repeat continued after compare hit");
   a_cnt_dec: assert property (@(posedge core_clk) disable iff (rst) // RQ11
      ok_done && !cmp_hit && (cnt_reg != '0) && !cmp_reg
      |=> (cnt_reg == $past(cnt_reg) - 1'b1) && (state_reg == PCR_ISSUE))
      else $error("counter did not step on success");
   a_zero_stop: assert property (@(posedge core_clk) disable iff (rst) // RQ10
      ok_done && (cnt_reg == '0) |=> (state_reg == PCR_IDLE) && (cnt_reg == '0))
      else $error("zero counter repeated or reloaded");
   a_fault_keep: assert property (@(posedge core_clk) disable iff (rst) // RQ13
      (state_reg == PCR_WAIT) && ap_rsp_valid && ap_rsp.fault
      |=> fault_reg && $stable(cnt_reg) && (state_reg == PCR_IDLE))
      else $error("fault did not stop sequence cleanly");
   a_sticky_hold: assert property (@(posedge core_clk) disable iff (rst) // RQ15
      cmp_reg && !(wr_stb && (wr_idx == PCR_CLEAR_OFS[3:2]) && wr_data[PCR_CMP_BIT])
      |=> cmp_reg)
      else $error("compare flag dropped without clear");
   a_fault_block: assert property (@(posedge core_clk) disable iff (rst) // RQ16
      fault_reg && (state_reg == PCR_IDLE) |=> state_reg == PCR_IDLE)
      else $error("transaction started while fault sticky");
   a_data_reuse: assert property (@(posedge core_clk) disable iff (rst) // RQ14
      ap_req_valid && (state_reg == PCR_ISSUE) && ($past(state_reg) == PCR_WAIT)
      |-> $stable(held_reg))
      else $error("repeat changed data");
   a_no_repeat: assert property (@(posedge core_clk) disable iff (rst) // RQ12
      ok_done && cmp_reg |=> (state_reg == PCR_IDLE) && $stable(cnt_reg))
      else $error("repeat ran with compare flag set");
   a_mode_load: assert property (@(posedge core_clk) disable iff (rst) // RQ5
      wr_stb && (wr_idx == PCR_CTRL_OFS[3:2]) && (state_reg == PCR_IDLE) && wr_strb[0]
      |=> mode_reg == $past(wr_data[PCR_MODE_HI:PCR_MODE_LO]))
      else $error("mode field not loaded");
   a_cnt_load: assert property (@(posedge core_clk) disable iff (rst) // RQ9
      wr_stb && (wr_idx == PCR_CTRL_OFS[3:2]) && (state_reg == PCR_IDLE) && wr_strb[1] &&
      wr_strb[2] |=> cnt_reg == $past(wr_data[PCR_CNT_HI:PCR_CNT_LO]))
      else $error("counter field not loaded");
   a_fault_hold: assert property (@(posedge core_clk) disable iff (rst) // RQ15
      fault_reg && !(wr_stb && (wr_idx == PCR_CLEAR_OFS[3:2]) && wr_data[PCR_FAULT_BIT])
      |=> fault_reg)
      else $error("fault flag dropped without clear");
   a_flag_clear: assert property (@(posedge core_clk) disable iff (rst) // RQ15
      wr_stb && (wr_idx == PCR_CLEAR_OFS[3:2]) && wr_data[PCR_CMP_BIT] && !ok_done
      |=> !cmp_reg)
      else $error("compare flag not cleared");
   a_no_false: assert property (@(posedge core_clk) disable iff (rst) // RQ2
      !cmp_reg && !(ok_done && req_wr_reg && pushed) |=> !cmp_reg)
      else $error("compare flag set without pushed result");
   a_req_hold: assert property (@(posedge core_clk) disable iff (rst) // RQ14
      ap_req_valid && !ap_req_ready |=> ap_req_valid && $stable(ap_req))
      else $error("request dropped or changed before taken");
   a_lane_mask: assert property (@(posedge core_clk) disable iff (rst) // RQ6 RQ17
      ok_done |-> all_match == (((held_reg ^ ap_rsp.data) & {{8{mask_reg[3]}},
      {8{mask_reg[2]}}, {8{mask_reg[1]}}, {8{mask_reg[0]}}}) == 32'h0000_0000))
      else $error("lane mask comparison wrong");
endmodule

// ===== verification/pcr_ap_model.sv
// Purpose: Access port model answering each taken request with scripted read data.
// Assumes: One request outstanding; the answer comes one to three cycles after the take.
// Notes: Idle response lines toggle so that stale data is never mistaken for an answer.
`timescale 1ns/10ps
module pcr_ap_model
   import pcr_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Access port side
   input wire pcr_req_t ap_req,
   input wire logic ap_req_valid,
   output logic ap_req_ready,
   output pcr_rsp_t ap_rsp,
   output logic ap_rsp_valid,
   // Script and tallies
   input wire logic [31:0] xor_pat,
   input wire logic [31:0] hit_at,
   input wire logic inv,
   input wire logic [31:0] fault_at,
   output logic [31:0] taken,
   output logic [31:0] wr_cnt,
   output logic [31:0] last_wr
);
   logic pend;
   logic [1:0] wait_n;
   logic [31:0] idx;
   pcr_req_t cur;
   always @(posedge core_clk) begin
      ap_rsp_valid <= 1'b0;
      ap_rsp <= ~ap_rsp;
      ap_req_ready <= 1'b0;
      idx = taken - 32'h1;
      if (rst) begin
         pend <= 1'b0;
         taken <= '0;
         wr_cnt <= '0;
         ap_rsp <= '0;
      end else if (pend) begin
         wait_n <= wait_n - 2'h1;
         if (wait_n == 2'h0) begin
            pend <= 1'b0;
            ap_rsp_valid <= 1'b1;
            ap_rsp.fault <= (idx == fault_at);
            // Scripted index gets the lane pattern and the rest differ in every bit; with inv set it is the other way round
            ap_rsp.data <= ((idx == hit_at) ^ inv) ? cur.data ^ xor_pat : ~cur.data;
         end
      end else if (ap_req_valid && ap_req_ready) begin
         pend <= 1'b1;
         cur <= ap_req;
         taken <= taken + 32'h1;
         wait_n <= 2'($urandom_range(0, 2));
         if (ap_req.write) begin
            wr_cnt <= wr_cnt + 32'h1;
            last_wr <= ap_req.data;
         end
      end else begin
         // Random stalls; never ready while an answer is owed
         ap_req_ready <= ($urandom_range(0, 3) != 0);
      end
   end
endmodule

// ===== verification/tb.sv
// Purpose: Self-checking bench for the pushed compare and repeat unit.
// Assumes: AXI4-Lite master here, access port model on the far side.
// Notes: Expected counts follow from the repeat and compare rules alone.
`timescale 1ns/10ps
module tb
   import pcr_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] s_awaddr = '0, s_wdata = '0, s_araddr = '0, s_rdata;
   logic [3:0] s_wstrb = 4'hF;
   logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
   logic s_arvalid = 1'b0, s_rready = 1'b0, inv = 1'b0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0] s_bresp, s_rresp;
   pcr_req_t ap_req;
   pcr_rsp_t ap_rsp;
   logic ap_req_valid, ap_req_ready, ap_rsp_valid;
   logic [31:0] xor_pat = '0, hit_at = '1, fault_at = '1;
   logic [31:0] taken, wr_cnt, last_wr, tk0, wr0, rv;
   int n_errors = 0;
   int checks = 0;

   initial begin
      forever #20 core_clk = ~core_clk;
   end

   pcr_unit i_pcr_unit (.core_clk, .rst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
      .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
      .s_rdata, .s_rresp, .s_rvalid, .s_rready, .ap_req, .ap_req_valid, .ap_req_ready, .ap_rsp,
      .ap_rsp_valid);
   pcr_ap_model i_pcr_ap_model (.core_clk, .rst, .ap_req, .ap_req_valid, .ap_req_ready, .ap_rsp,
      .ap_rsp_valid, .xor_pat, .hit_at, .inv, .fault_at, .taken, .wr_cnt, .last_wr);

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic conclude;
      $display("Checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic hang;
      n_errors++;
      $display("Error handshake expected answer seen none");
      conclude();
   endtask

   task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      int i;
      @(posedge core_clk);
      s_awaddr <= a;
      s_awvalid <= 1'b1;
      s_wdata <= d;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge core_clk);
         if (s_awvalid && s_awready) s_awvalid <= 1'b0;
         if (s_wvalid && s_wready) s_wvalid <= 1'b0;
         if (s_bvalid === 1'b1) break;
      end
      if (i == 100) hang();
      s_bready <= 1'b0;
      chk("write response", 32'(s_bresp), 32'(er));
   endtask

   task automatic axr(input logic [31:0] a, output logic [31:0] d, input logic [1:0] er);
      int i;
      @(posedge core_clk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge core_clk);
         if (s_arvalid && s_arready) s_arvalid <= 1'b0;
         if (s_rvalid === 1'b1) break;
      end
      if (i == 100) hang();
      d = s_rdata;
      s_rready <= 1'b0;
      chk("read response", 32'(s_rresp), 32'(er));
   endtask

   function automatic logic [31:0] f_ctrl(input logic [11:0] c, input logic [3:0] m,
      input logic [1:0] md, input logic cf, input logic ff);
      // Write bit always set: the bench never sends reads in a pushed mode
      return {8'h00, c, m, 2'b00, ff, cf, md, 1'b1, 1'b0};
   endfunction

   task automatic idle;
      int i;
      for (i = 0; i < 300; i++) begin
         axr(PCR_CTRL_OFS, rv, PCR_RESP_OKAY);
         if (rv[PCR_BUSY_BIT] === 1'b0) return;
      end
      hang();
   endtask

   task automatic run(input logic [11:0] c, input logic [3:0] m, input logic [1:0] md,
      input logic [31:0] d);
      axw(PCR_CTRL_OFS, f_ctrl(c, m, md, 1'b0, 1'b0), PCR_RESP_OKAY);
      tk0 = taken;
      wr0 = wr_cnt;
      axw(PCR_WDATA_OFS, d, PCR_RESP_OKAY);
      idle();
   endtask

   initial begin
      logic [31:0] d;
      logic [11:0] c;
      logic [3:0] m;
      logic [1:0] md;
      int k;
      int tn [4] = '{4, 4, 7, 1};
      d = $urandom(32'h4acb6d17);
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      axr(PCR_CTRL_OFS, rv, PCR_RESP_OKAY);
      chk("reset control", rv, 32'h0000_0F00);
      axr(32'h0000_0010, rv, PCR_RESP_SLVERR);
      chk("unmapped read", rv, 32'h0000_0000);
      axw(32'h0000_0010, 32'h00AB_C300, PCR_RESP_SLVERR);
      // Lane 0 alone carries mode and kind; mask and counter keep their values
      s_wstrb <= 4'h1;
      axw(PCR_CTRL_OFS, f_ctrl(12'hABC, 4'h3, PCR_MODE_VERIFY, 1'b0, 1'b0), PCR_RESP_OKAY);
      s_wstrb <= 4'hF;
      axr(PCR_CTRL_OFS, rv, PCR_RESP_OKAY);
      chk("lane 0 control", rv, f_ctrl(12'h0, 4'hF, PCR_MODE_VERIFY, 1'b0, 1'b0));
      $display("Test reset done");
      // Shortest count first; reserved mode must behave as normal
      for (k = 0; k < 3; k++) begin
         d = $urandom;
         md = (k == 2) ? PCR_MODE_RSVD : PCR_MODE_NORMAL;
         c = (k == 0) ? 12'h001 : 12'($urandom_range(2, 40));
         run(c, 4'hF, md, d);
         chk("transactions", taken - tk0, 32'(c) + 32'h1);
         chk("writes", wr_cnt - wr0, 32'(c) + 32'h1);
         chk("repeated data", last_wr, d);
         axr(PCR_CTRL_OFS, rv, PCR_RESP_OKAY);
         chk("spent control", rv, f_ctrl(12'h0, 4'hF, md, 1'b0, 1'b0));
      end
      $display("Test repeat done");
      fault_at <= taken + 32'h2;
      run(12'h5, 4'hF, PCR_MODE_NORMAL, $urandom);
      fault_at <= '1;
      chk("faulted transactions", taken - tk0, 32'h3);
      axr(PCR_CTRL_OFS, rv, PCR_RESP_OKAY);
      chk("fault stop", rv, f_ctrl(12'h3, 4'hF, PCR_MODE_NORMAL, 1'b0, 1'b1));
      tk0 = taken;
      axw(PCR_WDATA_OFS, $urandom, PCR_RESP_OKAY);
      idle();
      chk("discarded transactions", taken - tk0, 32'h0);
      chk("fault held", rv, f_ctrl(12'h3, 4'hF, PCR_MODE_NORMAL, 1'b0, 1'b1));
      axw(PCR_CLEAR_OFS, 32'h0000_0020, PCR_RESP_OKAY);
      axr(PCR_CTRL_OFS, rv, PCR_RESP_OKAY);
      chk("fault cleared", rv, f_ctrl(12'h3, 4'hF, PCR_MODE_NORMAL, 1'b0, 1'b0));
      $display("Test fault done");
      // Lanes 1 and 3 disagree on the scripted index; a full mask sees it
      xor_pat <= 32'hFF00_FF00;
      for (k = 0; k < 4; k++) begin
         md = k[0] ? PCR_MODE_VERIFY : PCR_MODE_COMPARE;
         m = (k < 2) ? 4'h5 : 4'hF;
         inv <= (k == 1);
         hit_at <= taken + 32'h3;
         d = $urandom;
         run(12'h6, m, md, d);
         chk("pushed transactions", taken - tk0, 32'(tn[k]));
         chk("pushed writes", wr_cnt - wr0, 32'h0);
         axr(PCR_CTRL_OFS, rv, PCR_RESP_OKAY);
         chk("pushed stop", rv, f_ctrl(12'(7 - tn[k]), m, md, tn[k] != 7, 1'b0));
         axr(PCR_WDATA_OFS, rv, PCR_RESP_OKAY);
         chk("held data", rv, d);
         axr(PCR_RDATA_OFS, rv, PCR_RESP_OKAY);
         chk("last read", rv, (k == 0) ? d ^ xor_pat : ~d);
         if (k != 3) axw(PCR_CLEAR_OFS, 32'h0000_0010, PCR_RESP_OKAY);
      end
      // Flag left set by the last verify: a normal request runs once
      d = $urandom;
      run(12'h4, 4'hF, PCR_MODE_NORMAL, d);
      chk("flagged transactions", taken - tk0, 32'h1);
      chk("flagged data", last_wr, d);
      chk("flag sticky", rv, f_ctrl(12'h4, 4'hF, PCR_MODE_NORMAL, 1'b1, 1'b0));
      axw(PCR_CLEAR_OFS, 32'h0000_0010, PCR_RESP_OKAY);
      axr(PCR_CTRL_OFS, rv, PCR_RESP_OKAY);
      chk("flag cleared", rv, f_ctrl(12'h4, 4'hF, PCR_MODE_NORMAL, 1'b0, 1'b0));
      $display("Test pushed done");
      conclude();
   end
endmodule
